/* headend_model.sv */
// Headend core model: offers flow descriptors one at a time.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/1ns
`include "pw_flow_regs.vh"
module headend_model (
  input  wire                  clk,
  input  wire                  inReady,
  output reg                   inValid,
  output reg  [`FLOW_BITS-1:0] inFlow,
  output reg  [`SEQ_BITS-1:0]  inSeq,
  output reg  [5:0]            inClass,
  output reg  [15:0]           inLength,
  output reg                   inRestart
);
  // One class value per flow, flow 2 expedited, others best effort
  function [5:0] classOf(input [1:0] f);
    classOf = (f == 2'h2) ? `RST_EXP_CLASS : 6'h00;
  endfunction

  // Timebase lag in master clock cycles, not used by the send task
  localparam integer TIMEBASE_LAG = 40;

  initial begin
    {inValid, inFlow, inSeq, inClass, inLength, inRestart} = 0;
  end

  task send(input [1:0] f, input [15:0] s, input [15:0] len, input r);
    @(posedge clk);
    inValid <= 1'b1;
    inFlow <= f;
    inSeq <= s;
    inClass <= classOf(f);
    inLength <= len;
    inRestart <= r;
    @(posedge clk);
    while (!inReady) @(posedge clk);
    inValid <= 1'b0;
    inFlow <= ~f;
    inSeq <= ~s;
    inClass <= ~classOf(f);
    inLength <= ~len;
    inRestart <= ~r;
  endtask
endmodule

/* pw_flow_framer.v */
// Edge device ingress framer: sequence checks, size checks and per-flow scheduling.
// Assumes a packet descriptor stream from the network port and an AXI4-Lite master.
`timescale 1ns/1ns
`include "pw_flow_regs.vh"

module pw_flow_framer (
  input  wire                  clk,
  input  wire                  rst_n,
  // AXI4-Lite slave
  input  wire [7:0]            s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [7:0]            s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Ingress descriptors
  input  wire                  inValid,
  output wire                  inReady,
  input  wire [`FLOW_BITS-1:0] inFlow,
  input  wire [`SEQ_BITS-1:0]  inSeq,
  input  wire [5:0]            inClass,
  input  wire [15:0]           inLength,
  input  wire                  inRestart,
  // Channel output
  output reg                   outValid,
  input  wire                  outReady,
  output reg  [`FLOW_BITS-1:0] outFlow,
  output reg  [`SEQ_BITS-1:0]  outSeq,
  output reg  [15:0]           outLength,
  output reg                   outExpedited,
  // Transmit check
  input  wire                  txValid,
  input  wire [15:0]           txLength,
  output reg                   txAccept,
  output reg                   txReject,
  output reg                   txDontFragment,
  output reg  [15:0]           replyMtu
);
  reg  [1:0]  ctrlReg;
  reg  [3:0]  flowHopReg;
  reg  [15:0] localMtuReg;
  reg  [15:0] peerMtuReg;
  reg  [15:0] gapCountReg;
  reg  [15:0] lateCountReg;
  reg  [15:0] sizeDropReg;
  reg  [5:0]  expClassReg;

  reg  [7:0]  awAddrReg;
  reg         awHeldReg;
  reg  [31:0] wDataReg;
  reg  [3:0]  wStrbReg;
  reg         wHeldReg;

  wire [`FLOW_COUNT-1:0] slotFull;
  wire [`FLOW_COUNT-1:0] slotUrgent;
  wire [`FLOW_COUNT-1:0] flowSeen;
  wire [`SEQ_BITS-1:0]   slotSeq [0:`FLOW_COUNT-1];
  wire [15:0]            slotLen [0:`FLOW_COUNT-1];
  wire [`SEQ_BITS-1:0]   flowExpect [0:`FLOW_COUNT-1];

  // Register index decode, shared by the read and write paths
  function [2:0] regIndex;
    input [7:0] addr;
    begin
      case (addr)
        `OFF_CTRL:       regIndex = `IDX_CTRL;
        `OFF_FLOW_HOP:   regIndex = `IDX_FLOW_HOP;
        `OFF_LOCAL_MTU:  regIndex = `IDX_LOCAL_MTU;
        `OFF_PEER_MTU:   regIndex = `IDX_PEER_MTU;
        `OFF_SEQ_STATUS: regIndex = `IDX_SEQ_STATUS;
        `OFF_SIZE_DROPS: regIndex = `IDX_SIZE_DROPS;
        `OFF_EXP_CLASS:  regIndex = `IDX_EXP_CLASS;
        default:         regIndex = `IDX_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  strb;
    integer      k;
    begin
      mergeBytes = oldWord;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          mergeBytes[k*8 +: 8] = newWord[k*8 +: 8];
        end
      end
    end
  endfunction

  // Lowest set flow in a mask, with a found flag on top
  function [`FLOW_BITS:0] firstSet;
    input [`FLOW_COUNT-1:0] mask;
    integer                 k;
    begin
      firstSet = {1'b0, {`FLOW_BITS{1'b0}}};
      for (k = `FLOW_COUNT - 1; k >= 0; k = k - 1) begin
        if (mask[k]) begin
          firstSet = {1'b1, k[`FLOW_BITS-1:0]};
        end
      end
    end
  endfunction

  // Write channel
  wire       doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;
  wire [2:0] wIdx    = regIndex(awAddrReg);
  wire       wrCtrl  = doWrite && (wIdx == `IDX_CTRL);
  wire       wrHop   = doWrite && (wIdx == `IDX_FLOW_HOP);
  wire       wrLocal = doWrite && (wIdx == `IDX_LOCAL_MTU);
  wire       wrPeer  = doWrite && (wIdx == `IDX_PEER_MTU);
  wire       wrStat  = doWrite && (wIdx == `IDX_SEQ_STATUS);
  wire       wrDrops = doWrite && (wIdx == `IDX_SIZE_DROPS);
  wire       wrClass = doWrite && (wIdx == `IDX_EXP_CLASS);
  wire [31:0] wMerged = mergeBytes(32'h00000000, wDataReg, wStrbReg);
  wire [31:0] localMerged = mergeBytes({16'h0000, localMtuReg}, wDataReg, wStrbReg);

  assign s_axi_awready = !awHeldReg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeldReg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk) begin
    if (!rst_n) begin
      awAddrReg    <= 8'h00;
      awHeldReg    <= 1'b0;
      wDataReg     <= 32'h00000000;
      wStrbReg     <= 4'h0;
      wHeldReg     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrReg <= s_axi_awaddr;
        awHeldReg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        wHeldReg <= 1'b1;
      end
      if (doWrite) begin
        awHeldReg    <= 1'b0;
        wHeldReg     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wIdx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  reg [31:0] readMux;
  always @* begin
    case (regIndex(s_axi_araddr))
      `IDX_CTRL:       readMux = {30'h0, ctrlReg};
      `IDX_FLOW_HOP:   readMux = {28'h0000000, flowHopReg};
      `IDX_LOCAL_MTU:  readMux = {16'h0000, localMtuReg};
      `IDX_PEER_MTU:   readMux = {16'h0000, peerMtuReg};
      `IDX_SEQ_STATUS: readMux = {lateCountReg, gapCountReg};
      `IDX_SIZE_DROPS: readMux = {16'h0000, sizeDropReg};
      `IDX_EXP_CLASS:  readMux = {26'h0, expClassReg};
      default:         readMux = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readMux;
      s_axi_rresp  <= (regIndex(s_axi_araddr) == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Ingress classification
  wire        inFire = inValid && inReady;
  wire        seqInOrder;
  wire        seqGap;
  wire        seqLate;
  wire        firstOfFlow = inRestart || !flowSeen[inFlow];
  wire        oversize = inLength > localMtuReg;
  wire        enabled = ctrlReg[`CTRL_ENABLE_BIT];
  wire        takeLate = inFire && enabled && !firstOfFlow && seqLate;
  wire        takeGap  = inFire && enabled && !firstOfFlow && seqGap;
  wire        takeSize = inFire && enabled && !takeLate && oversize;
  wire        seqLateEff = !firstOfFlow && seqLate;
  // Gap packets go on at once; late and oversize ones are dropped
  wire        store = inFire && enabled && !seqLateEff && !oversize;
  // Only the outer class value is looked at, never the inner frame
  wire        classUrgent = ctrlReg[`CTRL_USECLS_BIT] && (inClass == expClassReg);

  assign inReady = !slotFull[inFlow];

  seq_classifier seqCheck (
    .expectedSeq (flowExpect[inFlow]),
    .receivedSeq (inSeq),
    .isInOrder   (seqInOrder),
    .isGap       (seqGap),
    .isLate      (seqLate)
  );

  // Scheduler: expedited flows ahead of best effort ones
  wire [`FLOW_BITS:0] urgentPick = firstSet(slotFull & slotUrgent);
  wire [`FLOW_BITS:0] normalPick = firstSet(slotFull & ~slotUrgent);
  wire [`FLOW_BITS:0] pick = urgentPick[`FLOW_BITS] ? urgentPick : normalPick;
  wire                grant = pick[`FLOW_BITS] && (!outValid || outReady);

  genvar g;
  generate
    for (g = 0; g < `FLOW_COUNT; g = g + 1) begin : flowSlot
      reg                 fullReg;
      reg                 urgentReg;
      reg                 seenReg;
      reg [`SEQ_BITS-1:0] seqReg;
      reg [15:0]          lenReg;
      reg [`SEQ_BITS-1:0] expectReg;
      wire                hit = inFire && enabled && (inFlow == g);

      always @(posedge clk) begin
        if (!rst_n) begin
          fullReg   <= 1'b0;
          urgentReg <= 1'b0;
          seenReg   <= 1'b0;
          seqReg    <= {`SEQ_BITS{1'b0}};
          lenReg    <= 16'h0000;
          expectReg <= {`SEQ_BITS{1'b0}};
        end else begin
          if (grant && (pick[`FLOW_BITS-1:0] == g)) begin
            fullReg <= 1'b0;
          end
          if (store && (inFlow == g)) begin
            fullReg   <= 1'b1;
            urgentReg <= flowHopReg[g] || classUrgent;
            seqReg    <= inSeq;
            lenReg    <= inLength;
          end
          // Expected number skips past any gap so skipped ones become late
          // No reorder buffer: an out-of-order packet counts as late
          if (hit && !seqLateEff) begin
            seenReg   <= 1'b1;
            expectReg <= inSeq + {{(`SEQ_BITS-1){1'b0}}, 1'b1};
          end
        end
      end

      assign slotFull[g]   = fullReg;
      assign slotUrgent[g] = urgentReg;
      assign flowSeen[g]   = seenReg;
      assign slotSeq[g]    = seqReg;
      assign slotLen[g]    = lenReg;
      assign flowExpect[g] = expectReg;
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_n) begin
      outValid     <= 1'b0;
      outFlow      <= {`FLOW_BITS{1'b0}};
      outSeq       <= {`SEQ_BITS{1'b0}};
      outLength    <= 16'h0000;
      outExpedited <= 1'b0;
    end else if (grant) begin
      outValid     <= 1'b1;
      outFlow      <= pick[`FLOW_BITS-1:0];
      outSeq       <= slotSeq[pick[`FLOW_BITS-1:0]];
      outLength    <= slotLen[pick[`FLOW_BITS-1:0]];
      outExpedited <= urgentPick[`FLOW_BITS];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

  // Control registers and counters; a counted event wins over a clear
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrlReg      <= `RST_CTRL;
      flowHopReg   <= `RST_FLOW_HOP;
      localMtuReg  <= `MIN_MTU_BYTES;
      peerMtuReg   <= `MIN_MTU_BYTES;
      gapCountReg  <= 16'h0000;
      lateCountReg <= 16'h0000;
      sizeDropReg  <= 16'h0000;
      expClassReg  <= `RST_EXP_CLASS;
    end else begin
      if (wrCtrl) begin
        ctrlReg <= wMerged[1:0];
      end
      if (wrHop) begin
        flowHopReg <= wMerged[3:0];
      end
      // Static session size, never below the minimum payload
      if (wrLocal) begin
        localMtuReg <= (localMerged[15:0] < `MIN_MTU_BYTES) ?
                       `MIN_MTU_BYTES : localMerged[15:0];
      end
      if (wrPeer) begin
        peerMtuReg <= wMerged[15:0];
      end
      if (wrClass) begin
        expClassReg <= wMerged[5:0];
      end
      gapCountReg  <= (wrStat ? 16'h0000 : gapCountReg) +
                      {15'h0000, takeGap};
      lateCountReg <= (wrStat ? 16'h0000 : lateCountReg) +
                      {15'h0000, takeLate};
      sizeDropReg  <= (wrDrops ? 16'h0000 : sizeDropReg) +
                      {15'h0000, takeSize};
    end
  end

  // Transmit size check and header flag
  always @(posedge clk) begin
    if (!rst_n) begin
      txAccept       <= 1'b0;
      txReject       <= 1'b0;
      txDontFragment <= 1'b1;
      replyMtu       <= `MIN_MTU_BYTES;
    end else begin
      txAccept       <= txValid && (txLength <= peerMtuReg);
      txReject       <= txValid && (txLength > peerMtuReg);
      txDontFragment <= 1'b1;
      replyMtu       <= localMtuReg;
    end
  end
endmodule

/* pw_flow_framer_props.sv */
// Concurrent checks on the flow framer ports.
// Assumes it is bound into pw_flow_framer and sees only its ports.
`timescale 1ns/1ns
`include "pw_flow_regs.vh"
module pw_flow_framer_props (
  input wire                  clk,
  input wire                  rst_n,
  input wire                  s_axi_awvalid,
  input wire                  s_axi_awready,
  input wire                  s_axi_wvalid,
  input wire                  s_axi_wready,
  input wire [1:0]            s_axi_bresp,
  input wire                  s_axi_bvalid,
  input wire                  s_axi_bready,
  input wire                  s_axi_arvalid,
  input wire                  s_axi_arready,
  input wire                  s_axi_rvalid,
  input wire                  outValid,
  input wire                  outReady,
  input wire [`FLOW_BITS-1:0] outFlow,
  input wire [`SEQ_BITS-1:0]  outSeq,
  input wire [15:0]           outLength,
  input wire                  outExpedited,
  input wire                  txValid,
  input wire                  txAccept,
  input wire                  txReject,
  input wire                  txDontFragment,
  input wire [15:0]           replyMtu
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Address and data taken together
  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_outStall;
    outValid && !outReady;
  endsequence

  property p_wrResp;
    s_wrTaken |-> !s_axi_bvalid ##2 s_axi_bvalid;
  endproperty
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rdResp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_awBlock;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  property p_df;
    txDontFragment;
  endproperty
  property p_txAns;
    txValid |=> txAccept != txReject;
  endproperty
  property p_txQuiet;
    !txValid |=> !txAccept && !txReject;
  endproperty
  property p_mtuFloor;
    replyMtu >= `MIN_MTU_BYTES;
  endproperty
  property p_outHold;
    s_outStall |=> outValid && $stable({outFlow, outSeq, outLength, outExpedited});
  endproperty

  a_wrResp: assert property (p_wrResp) else $error("write response late");
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  a_rdResp: assert property (p_rdResp) else $error("read data late");
  a_awBlock: assert property (p_awBlock) else $error("address taken early");
  a_df: assert property (p_df) else $error("fragment flag low");
  a_txAns: assert property (p_txAns) else $error("size answer wrong");
  a_txQuiet: assert property (p_txQuiet) else $error("size answer unasked");
  a_mtuFloor: assert property (p_mtuFloor) else $error("reply size too small");
  a_outHold: assert property (p_outHold) else $error("channel item changed");
endmodule

bind pw_flow_framer pw_flow_framer_props u_props (
  .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .outValid, .outReady, .outFlow, .outSeq, .outLength, .outExpedited,
  .txValid, .txAccept, .txReject, .txDontFragment, .replyMtu);

/* pw_flow_regs.vh */
// Register offsets, field positions, reset values and limits of the flow framer.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz clock.
`ifndef PW_FLOW_REGS_VH
`define PW_FLOW_REGS_VH

`define OFF_CTRL        8'h00
`define OFF_FLOW_HOP    8'h04
`define OFF_LOCAL_MTU   8'h08
`define OFF_PEER_MTU    8'h0C
`define OFF_SEQ_STATUS  8'h10
`define OFF_SIZE_DROPS  8'h14
`define OFF_EXP_CLASS   8'h18

`define IDX_CTRL        3'd0
`define IDX_FLOW_HOP    3'd1
`define IDX_LOCAL_MTU   3'd2
`define IDX_PEER_MTU    3'd3
`define IDX_SEQ_STATUS  3'd4
`define IDX_SIZE_DROPS  3'd5
`define IDX_EXP_CLASS   3'd6
`define IDX_NONE        3'd7

`define CTRL_ENABLE_BIT 0
`define CTRL_USECLS_BIT 1

`define RST_CTRL        2'h1
`define RST_FLOW_HOP    4'h0
`define MIN_MTU_BYTES   16'h05DC
`define RST_EXP_CLASS   6'h2E

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define FLOW_COUNT      4
`define FLOW_BITS       2
`define SEQ_BITS        16

`endif

/* seq_classifier.v */
// Sorts a received sequence number against the expected one of its flow.
// Assumes 16-bit wrapping sequence counters; purely combinational.
`timescale 1ns/1ns
`include "pw_flow_regs.vh"

module seq_classifier (
  input  wire [`SEQ_BITS-1:0] expectedSeq,
  input  wire [`SEQ_BITS-1:0] receivedSeq,
  output wire                 isInOrder,
  output wire                 isGap,
  output wire                 isLate
);
  wire [`SEQ_BITS-1:0] distance;

  // Modular distance, so wraparound is a plain step
  assign distance  = receivedSeq - expectedSeq;
  assign isInOrder = (distance == {`SEQ_BITS{1'b0}});
  assign isGap     = !isInOrder && !distance[`SEQ_BITS-1];
  assign isLate    = distance[`SEQ_BITS-1];
endmodule

/* test_pw_flow_framer.sv */
// Bench for the flow framer: register bus, ingress, channel and size checks.
// Assumes headend_model drives the ingress port.
`timescale 1ns/1ns
`include "pw_flow_regs.vh"
module test_pw_flow_framer;
  reg         clk, rst_n, outReady, txValid;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, lastData;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [15:0] txLength;
  reg  [1:0]  lastResp, f;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, inFlow, outFlow;
  wire [31:0] s_axi_rdata;
  wire        inValid, inReady, inRestart, outValid, outExpedited;
  wire        txAccept, txReject, txDontFragment;
  wire [15:0] inSeq, inLength, outSeq, outLength, replyMtu;
  wire [5:0]  inClass;
  reg  [18:0] got[$];
  reg  [15:0] gotLen[$];
  reg  [15:0] expLen;
  int         failures, checked, cycles, k;

  pw_flow_framer uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .inValid(inValid), .inReady(inReady), .inFlow(inFlow),
    .inSeq(inSeq), .inClass(inClass), .inLength(inLength), .inRestart(inRestart),
    .outValid(outValid), .outReady(outReady), .outFlow(outFlow), .outSeq(outSeq),
    .outLength(outLength), .outExpedited(outExpedited), .txValid(txValid),
    .txLength(txLength), .txAccept(txAccept), .txReject(txReject),
    .txDontFragment(txDontFragment), .replyMtu(replyMtu));

  headend_model hc (.clk(clk), .inReady(inReady), .inValid(inValid), .inFlow(inFlow),
    .inSeq(inSeq), .inClass(inClass), .inLength(inLength), .inRestart(inRestart));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (outValid && outReady) got.push_back({outExpedited, outFlow, outSeq});
    if (outValid && outReady) gotLen.push_back(outLength);
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      end_sim;
    end
  end

  task cmp(input string n, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task axiWrite(input [7:0] a, input [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    lastResp = s_axi_bresp;
  endtask

  task rdChk(input string n, input [7:0] a, input [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    lastData = s_axi_rdata;
    lastResp = s_axi_rresp;
    cmp(n, e, lastData);
  endtask

  task txChk(input [15:0] len, input e);
    @(posedge clk);
    txValid <= 1'b1;
    txLength <= len;
    @(posedge clk);
    txValid <= 1'b0;
    txLength <= ~len;
    @(posedge clk);
    cmp("txAccept", {31'h0, e}, {31'h0, txAccept});
    cmp("txReject", {31'h0, !e}, {31'h0, txReject});
    cmp("txDontFragment", 32'h1, {31'h0, txDontFragment});
  endtask

  task drainChk(input [18:0] e);
    wait (got.size() > 0);
    cmp("channel", {13'h0000, e}, {13'h0000, got.pop_front()});
    cmp("length", {16'h0000, expLen}, {16'h0000, gotLen.pop_front()});
  endtask

  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {rst_n, outReady, txValid, txLength, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hF;
    expLen = 16'h0040;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    outReady <= 1'b1;
    rdChk("ctrl", `OFF_CTRL, 32'h1);
    rdChk("flowHop", `OFF_FLOW_HOP, 32'h0);
    rdChk("localMtu", `OFF_LOCAL_MTU, {16'h0, `MIN_MTU_BYTES});
    rdChk("peerMtu", `OFF_PEER_MTU, {16'h0, `MIN_MTU_BYTES});
    rdChk("expClass", `OFF_EXP_CLASS, 32'h2E);
    rdChk("unmapped", 8'h1C, 32'h0);
    cmp("unmappedResp", {30'h0, `RESP_SLVERR}, {30'h0, lastResp});
    cmp("replyMtu", {16'h0, `MIN_MTU_BYTES}, {16'h0, replyMtu});
    axiWrite(`OFF_LOCAL_MTU, 32'h3E8);
    rdChk("localMtuFloor", `OFF_LOCAL_MTU, {16'h0, `MIN_MTU_BYTES});
    axiWrite(`OFF_LOCAL_MTU, 32'h7D0);
    rdChk("localMtu", `OFF_LOCAL_MTU, 32'h7D0);
    cmp("replyMtu", 32'h7D0, {16'h0, replyMtu});
    axiWrite(`OFF_PEER_MTU, 32'h640);
    cmp("peerWrResp", {30'h0, `RESP_OKAY}, {30'h0, lastResp});
    axiWrite(8'h1C, 32'h0);
    cmp("unmappedWrResp", {30'h0, `RESP_SLVERR}, {30'h0, lastResp});
    txChk(16'h0640, 1'b1);
    txChk(16'h0641, 1'b0);
    // Gap, two late arrivals, then resume
    hc.send(2'h0, 16'h000A, 16'h0040, 1'b1);
    hc.send(2'h0, 16'h000B, 16'h0040, 1'b0);
    hc.send(2'h0, 16'h000E, 16'h0040, 1'b0);
    hc.send(2'h0, 16'h000C, 16'h0040, 1'b0);
    hc.send(2'h0, 16'h000D, 16'h0040, 1'b0);
    hc.send(2'h0, 16'h000F, 16'h0040, 1'b0);
    drainChk(19'h0000A);
    drainChk(19'h0000B);
    drainChk(19'h0000E);
    drainChk(19'h0000F);
    rdChk("seqStatus", `OFF_SEQ_STATUS, 32'h0002_0001);
    hc.send(2'h1, 16'hFFFF, 16'h0040, 1'b1);
    hc.send(2'h1, 16'h0000, 16'h0040, 1'b0);
    drainChk(19'h1FFFF);
    drainChk(19'h10000);
    rdChk("seqWrap", `OFF_SEQ_STATUS, 32'h0002_0001);
    hc.send(2'h3, 16'h0005, 16'h07D1, 1'b1);
    hc.send(2'h3, 16'h0006, 16'h05DC, 1'b0);
    expLen = 16'h05DC;
    drainChk(19'h30006);
    expLen = 16'h0040;
    rdChk("sizeDrops", `OFF_SIZE_DROPS, 32'h1);
    for (k = 0; k < 2; k++) begin
      if (k == 0) begin
        axiWrite(`OFF_FLOW_HOP, 32'h8);
      end else begin
        axiWrite(`OFF_FLOW_HOP, 32'h0);
        axiWrite(`OFF_CTRL, 32'h3);
      end
      f = (k == 0) ? 2'h3 : 2'h2;
      outReady <= 1'b0;
      hc.send(2'h1, 16'h0000, 16'h0040, 1'b1);
      hc.send(2'h0, 16'h0000, 16'h0040, 1'b1);
      hc.send(f, 16'h0000, 16'h0040, 1'b1);
      repeat (2) @(posedge clk);
      outReady <= 1'b1;
      drainChk(19'h10000);
      drainChk({1'b1, f, 16'h0000});
      drainChk(19'h00000);
    end
    end_sim;
  end
endmodule
